// [rtl/tdb_cfg.svh]
// register offsets, field positions, reset values and cause codes
// for the tile debug breakpoint unit; definitions only
`ifndef TDB_CFG_SVH
`define TDB_CFG_SVH

// processor-status offsets (word indices on the status port)
`define TDB_OFS_SSR 8'h10
`define TDB_OFS_SPC 8'h11
`define TDB_OFS_SSP 8'h12
`define TDB_OFS_OP1 8'h13
`define TDB_OFS_OP2 8'h14
`define TDB_OFS_TYPE 8'h15
`define TDB_OFS_DATA 8'h16
`define TDB_OFS_STOP 8'h18
`define TDB_OFS_SCR 8'h20
`define TDB_OFS_IBA 8'h30
`define TDB_OFS_IBC 8'h40

// saved status word: writable bits and the read-only issue mode bit
`define TDB_SSR_WMASK 11'h6df
`define TDB_SSR_DI_NOW 8
`define TDB_SSR_RSVD 11'h020 // reserved bit, never captured

// cause register fields
`define TDB_TYP_CAUSE_LSB 0
`define TDB_TYP_THR_LSB 8
`define TDB_TYP_IDX_LSB 16

// breakpoint control fields
`define TDB_IBC_EN_BIT 0
`define TDB_IBC_NE_BIT 1
`define TDB_IBC_THR_LSB 16

// cause encodings
`define TDB_CAUSE_NONE 3'h0
`define TDB_CAUSE_HOST 3'h1
`define TDB_CAUSE_DEBUG_CALL_INSTRUCTION 3'h2
`define TDB_CAUSE_IBRK 3'h3
`define TDB_CAUSE_DWATCH 3'h4
`define TDB_CAUSE_RWATCH 3'h5

// reset values
`define TDB_RST_CAUSE 3'h0
`define TDB_RST_IBC_THR 8'h00
`define TDB_RST_WORD 32'h0000_0000

`endif

// [rtl/tdb_ibreak.sv]
// four instruction address comparators with thread masks
// assumes pc and thread come from the issuing pipeline on the same clock
`default_nettype none
module tdb_ibreak import tdb_pkg::*; (
	input wire logic [3:0][31:0] ibAddr,
	input wire logic [3:0] ibEn,
	input wire logic [3:0] ibNe,
	input wire logic [3:0][7:0] ibThr,
	input wire logic exValid,
	input wire logic [7:0] exThread,
	input wire logic [31:0] exPc,
	output logic hit,
	output logic [1:0] hitIdx
);
	logic [3:0] match;

	// threads numbered above seven never match any mask bit
	function automatic logic thrOk(input logic [7:0] mask,
		input logic [7:0] thr);
		thrOk = (thr[7:3] == 5'h00) && mask[thr[2:0]];
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gCmp
			assign match[g] = exValid && ibEn[g]
				&& thrOk(ibThr[g], exThread)
				&& ((exPc == ibAddr[g]) ^ ibNe[g]);
		end
	endgenerate

	// lowest numbered comparator wins
	always_comb begin
		hit = |match;
		hitIdx = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (match[i]) begin
				hitIdx = 2'(i);
			end
		end
	end
endmodule // tdb_ibreak
`default_nettype wire

// [rtl/tdb_pkg.sv]
// types shared by the tile debug breakpoint unit
// assumes tdb_cfg.svh holds the numeric constants
`default_nettype none
package tdb_pkg;
	typedef enum logic {TDB_RUN, TDB_HALT} tdb_mode_t;

	typedef struct packed {
		tdb_mode_t mode;
		logic [10:0] thread_status_word;
		logic [31:0] saved_program_counter;
		logic [31:0] saved_stack_pointer;
		logic [7:0] op1;
		logic [4:0] op2;
		logic [2:0] cause;
		logic [7:0] cthr;
		logic [1:0] cidx;
		logic [31:0] cdata;
		logic [7:0] stop;
		logic [3:0][31:0] ibAddr;
		logic [3:0] ibEn;
		logic [3:0] ibNe;
		logic [3:0][7:0] ibThr;
		logic [31:0] rdData;
		logic rdScr;
		logic rdValid;
		logic cfgRdV;
		logic hostS1;
		logic hostS2;
		logic hostS3;
		logic enter;
	} tdb_state_t;

	typedef struct packed {
		logic [7:0][31:0] word;
		logic [31:0] rdData;
	} tdb_mem_t;
endpackage
`default_nettype wire

// [rtl/tdb_scratch_mem.sv]
// eight-word scratch store shared by both register spaces
// assumes one write port and one read port, arbitrated by the caller
`default_nettype none
module tdb_scratch_mem import tdb_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic [2:0] wrAddr,
	input wire logic [31:0] wrData,
	input wire logic [2:0] rdAddr,
	output logic [31:0] rdData
);
	tdb_mem_t s_r;
	tdb_mem_t s_nxt;

	// write one word; read data always registered
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdData = s_r.word[rdAddr];
		if (wrEn) begin
			s_nxt.word[wrAddr] = wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdData = s_r.rdData;
endmodule // tdb_scratch_mem
`default_nettype wire

// [rtl/tdb_unit.sv]
// tile debug breakpoint unit: debug entry capture, cause recording,
// stop mask, shared scratch words and four instruction breakpoints.
// assumes a single-cycle status port and a config port on clk; the
// host request arrives from the test access logic asynchronously.
`include "tdb_cfg.svh"
`default_nettype none

module tdb_unit import tdb_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] psAddr,
	input wire logic psWrEn,
	input wire logic psRdEn,
	input wire logic [31:0] psWrData,
	output logic [31:0] psRdData,
	output logic psRdValid,
	input wire logic [2:0] cfgAddr,
	input wire logic cfgWrEn,
	input wire logic cfgRdEn,
	input wire logic [31:0] cfgWrData,
	output logic [31:0] cfgRdData,
	output logic cfgRdValid,
	output logic cfgReady,
	input wire logic exValid,
	input wire logic [7:0] exThread,
	input wire logic [31:0] exPc,
	input wire logic [10:0] exSsr,
	input wire logic [31:0] exSp,
	input wire logic hostReq,
	input wire logic dcallReq,
	input wire logic dwatchHit,
	input wire logic [1:0] dwatchIdx,
	input wire logic [31:0] dwatchAddr,
	input wire logic rwatchHit,
	input wire logic [1:0] rwatchIdx,
	input wire logic [31:0] rwatchRes,
	input wire logic dretReq,
	output logic debugEnter,
	output logic debugMode,
	output logic [7:0] threadStop,
	output logic [7:0] getRegThread,
	output logic [4:0] getRegIndex
);
	tdb_state_t s_r;
	tdb_state_t s_nxt;
	logic bpHit;
	logic [1:0] bpIdx;
	logic hostEdge;
	logic trig;
	logic psScr;
	logic memWr;
	logic [2:0] memWrAddr;
	logic [31:0] memWrData;
	logic [2:0] memRdAddr;
	logic [31:0] memRdData;

	// decode of a status-port address into a register group
	function automatic logic inGroup(input logic [7:0] a,
		input logic [7:0] base, input logic [7:0] span);
		inGroup = (a >= base) && (a < 8'(base + span));
	endfunction

	tdb_ibreak uIbreak (
		.ibAddr(s_r.ibAddr),
		.ibEn(s_r.ibEn),
		.ibNe(s_r.ibNe),
		.ibThr(s_r.ibThr),
		.exValid(exValid),
		.exThread(exThread),
		.exPc(exPc),
		.hit(bpHit),
		.hitIdx(bpIdx)
	);

	// scratch words: status port first, config port refused in that cycle via cfgReady
	assign psScr = inGroup(psAddr, `TDB_OFS_SCR, 8'h08);
	assign cfgReady = !((psWrEn || psRdEn) && psScr);
	assign memWr = (psWrEn && psScr) || (cfgWrEn && cfgReady);
	assign memWrAddr = (psWrEn && psScr) ? psAddr[2:0] : cfgAddr;
	assign memWrData = (psWrEn && psScr) ? psWrData : cfgWrData;
	assign memRdAddr = (psRdEn && psScr) ? psAddr[2:0] : cfgAddr;

	tdb_scratch_mem uScratch (
		.clk(clk),
		.rst_b(rst_b),
		.wrEn(memWr),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		.rdAddr(memRdAddr),
		.rdData(memRdData)
	);

	// host request edge is taken from the synchronised stages only
	assign hostEdge = s_r.hostS2 && !s_r.hostS3;
	// any debug event while threads run enters debug mode
	assign trig = (s_r.mode == TDB_RUN) && (hostEdge
		|| (exValid && (dcallReq || dwatchHit || rwatchHit)) || bpHit);

	// next state: sync stages, entry capture, return, register writes
	always_comb begin
		s_nxt = s_r;
		s_nxt.hostS1 = hostReq;
		s_nxt.hostS2 = s_r.hostS1;
		s_nxt.hostS3 = s_r.hostS2;
		s_nxt.enter = 1'b0;
		s_nxt.rdValid = psRdEn;
		s_nxt.rdScr = psRdEn && psScr;
		s_nxt.cfgRdV = cfgRdEn && cfgReady;
		s_nxt.rdData = '0;

		// software writes; entry capture below overrides them
		if (psWrEn) begin
			unique case (psAddr)
				`TDB_OFS_SSR: s_nxt.thread_status_word = (psWrData[10:0]
					& `TDB_SSR_WMASK)
					| (s_r.thread_status_word & ~`TDB_SSR_WMASK);
				`TDB_OFS_SPC: s_nxt.saved_program_counter = psWrData;
				`TDB_OFS_SSP: s_nxt.saved_stack_pointer = psWrData;
				`TDB_OFS_OP1: s_nxt.op1 = psWrData[7:0];
				`TDB_OFS_OP2: s_nxt.op2 = psWrData[4:0];
				`TDB_OFS_TYPE: begin
					s_nxt.cause = psWrData[`TDB_TYP_CAUSE_LSB +: 3];
					s_nxt.cthr = psWrData[`TDB_TYP_THR_LSB +: 8];
					s_nxt.cidx = psWrData[`TDB_TYP_IDX_LSB +: 2];
				end
				`TDB_OFS_DATA: s_nxt.cdata = psWrData;
				`TDB_OFS_STOP: s_nxt.stop = psWrData[7:0];
				default: begin
				end
			endcase
			for (int i = 0; i < 4; i++) begin
				if (psAddr == 8'(`TDB_OFS_IBA + i)) begin
					s_nxt.ibAddr[i] = psWrData;
				end
				if (psAddr == 8'(`TDB_OFS_IBC + i)) begin
					s_nxt.ibEn[i] = psWrData[`TDB_IBC_EN_BIT];
					s_nxt.ibNe[i] = psWrData[`TDB_IBC_NE_BIT];
					s_nxt.ibThr[i] =
						psWrData[`TDB_IBC_THR_LSB +: 8];
				end
			end
		end

		// register reads, answered one cycle later
		if (psRdEn) begin
			unique case (psAddr)
				`TDB_OFS_SSR: s_nxt.rdData = {21'h0, s_r.thread_status_word};
				`TDB_OFS_SPC: s_nxt.rdData = s_r.saved_program_counter;
				`TDB_OFS_SSP: s_nxt.rdData = s_r.saved_stack_pointer;
				`TDB_OFS_OP1: s_nxt.rdData = {24'h0, s_r.op1};
				`TDB_OFS_OP2: s_nxt.rdData = {27'h0, s_r.op2};
				`TDB_OFS_TYPE: s_nxt.rdData = {14'h0, s_r.cidx,
					s_r.cthr, 5'h0, s_r.cause};
				`TDB_OFS_DATA: s_nxt.rdData = s_r.cdata;
				`TDB_OFS_STOP: s_nxt.rdData = {24'h0, s_r.stop};
				default: s_nxt.rdData = '0;
			endcase
			for (int i = 0; i < 4; i++) begin
				if (psAddr == 8'(`TDB_OFS_IBA + i)) begin
					s_nxt.rdData = s_r.ibAddr[i];
				end
				if (psAddr == 8'(`TDB_OFS_IBC + i)) begin
					s_nxt.rdData = {8'h0, s_r.ibThr[i], 14'h0,
						s_r.ibNe[i], s_r.ibEn[i]};
				end
			end
		end

		// debug entry: snapshot the interrupted thread
		if (trig) begin
			s_nxt.mode = TDB_HALT;
			s_nxt.enter = 1'b1;
			s_nxt.thread_status_word = exSsr & ~`TDB_SSR_RSVD;
			s_nxt.saved_program_counter = exPc;
			s_nxt.saved_stack_pointer = exSp;
			s_nxt.cdata = `TDB_RST_WORD;
			// host wins, then call, breakpoint, data, resource
			if (hostEdge) begin
				s_nxt.cause = `TDB_CAUSE_HOST;
				s_nxt.cthr = 8'h00;
				s_nxt.cidx = 2'h0;
			end else if (exValid && dcallReq) begin
				s_nxt.cause = `TDB_CAUSE_DEBUG_CALL_INSTRUCTION;
				s_nxt.cthr = exThread;
				s_nxt.cidx = 2'h0;
			end else if (bpHit) begin
				s_nxt.cause = `TDB_CAUSE_IBRK;
				s_nxt.cthr = exThread;
				s_nxt.cidx = bpIdx;
			end else if (dwatchHit) begin
				s_nxt.cause = `TDB_CAUSE_DWATCH;
				s_nxt.cthr = exThread;
				s_nxt.cidx = dwatchIdx;
				s_nxt.cdata = dwatchAddr;
			end else begin
				s_nxt.cause = `TDB_CAUSE_RWATCH;
				s_nxt.cthr = exThread;
				s_nxt.cidx = rwatchIdx;
				s_nxt.cdata = rwatchRes;
			end
		end else if (s_r.mode == TDB_HALT && dretReq) begin
			s_nxt.mode = TDB_RUN;
		end
	end

	// single state register; cause and breakpoint controls reset clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs
	assign psRdData = s_r.rdScr ? memRdData : s_r.rdData;
	assign psRdValid = s_r.rdValid;
	assign cfgRdData = memRdData;
	assign cfgRdValid = s_r.cfgRdV;
	assign debugEnter = s_r.enter;
	assign debugMode = (s_r.mode == TDB_HALT);
	// stopped threads are released while the debugger runs
	assign threadStop = debugMode ? 8'h00 : s_r.stop;
	assign getRegThread = s_r.op1;
	assign getRegIndex = s_r.op2;

	// checks
	ssr_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig |=> debugMode && s_r.thread_status_word == ($past(exSsr) & ~`TDB_SSR_RSVD))
		else $error("status word not captured on entry");
	pc_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig |=> s_r.saved_program_counter == $past(exPc) && debugEnter)
		else $error("program counter not captured on entry");
	sp_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig |=> s_r.saved_stack_pointer == $past(exSp))
		else $error("stack pointer not captured on entry");
	ssr_ro_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
		psWrEn && psAddr == `TDB_OFS_SSR && !trig
		|=> s_r.thread_status_word[`TDB_SSR_DI_NOW] == $past(s_r.thread_status_word[`TDB_SSR_DI_NOW]))
		else $error("read-only issue mode bit changed by write");
	host_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig && hostEdge |=> s_r.cause == `TDB_CAUSE_HOST
		&& s_r.cthr == 8'h00 && s_r.cidx == 2'h0)
		else $error("host entry must record thread and index zero");
	ibrk_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig && !hostEdge && !(exValid && dcallReq) && bpHit
		|=> s_r.cause == `TDB_CAUSE_IBRK && s_r.cidx == $past(bpIdx))
		else $error("breakpoint entry recorded wrongly");
	watch_data_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig && !hostEdge && !dcallReq && !bpHit && dwatchHit
		|=> s_r.cdata == $past(dwatchAddr))
		else $error("watch address not recorded");
	stop_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
		debugMode && dretReq |=> !debugMode && threadStop == s_r.stop)
		else $error("stop mask not applied after return");
	cause_legal_a: assert property (@(posedge clk) disable iff (!rst_b)
		!psWrEn ##1 debugEnter |-> s_r.cause inside {[3'h1:3'h5]})
		else $error("illegal cause code on entry");
	rd_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		psRdEn && psAddr == `TDB_OFS_OP2 |=> psRdValid
		&& psRdData[31:5] == 27'h0)
		else $error("reserved operand bits read nonzero");
	// operand, stop mask, breakpoint, entry cause, scratch read and reserved field checks
	op_thread_a: assert property (@(posedge clk) disable iff (!rst_b)
		psWrEn && psAddr == `TDB_OFS_OP1
		|=> getRegThread == $past(psWrData[7:0]))
		else $error("thread operand not taken from write");
	op_index_a: assert property (@(posedge clk) disable iff (!rst_b)
		psWrEn && psAddr == `TDB_OFS_OP2
		|=> getRegIndex == $past(psWrData[4:0]))
		else $error("index operand not taken from write");
	stop_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		psWrEn && psAddr == `TDB_OFS_STOP && !debugMode
		|=> debugMode || threadStop == $past(psWrData[7:0]))
		else $error("stop mask write not applied while running");
	entry_release_a: assert property (@(posedge clk) disable iff (!rst_b)
		debugEnter |-> debugMode && threadStop == 8'h00)
		else $error("threads still stopped after debug entry");
	halt_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
		debugMode |=> !debugEnter)
		else $error("debug event taken while in debug mode");
	ibrk_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.ibEn == 4'h0 |-> !bpHit)
		else $error("breakpoint fired while none armed");
	ibrk_thread_a: assert property (@(posedge clk) disable iff (!rst_b)
		bpHit |-> exThread[7:3] == 5'h00
		&& s_r.ibThr[bpIdx][exThread[2:0]])
		else $error("breakpoint fired for a masked thread");
	ibrk_cond_a: assert property (@(posedge clk) disable iff (!rst_b)
		bpHit |-> s_r.ibEn[bpIdx]
		&& ((exPc == s_r.ibAddr[bpIdx]) != s_r.ibNe[bpIdx]))
		else $error("breakpoint condition not met");
	debug_call_instruction_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig && !hostEdge && exValid && dcallReq
		|=> s_r.cause == `TDB_CAUSE_DEBUG_CALL_INSTRUCTION && s_r.cidx == 2'h0
		&& s_r.cthr == $past(exThread))
		else $error("debug call entry recorded wrongly");
	rwatch_data_a: assert property (@(posedge clk) disable iff (!rst_b)
		trig && !hostEdge && !dcallReq && !bpHit && !dwatchHit
		|=> s_r.cause == `TDB_CAUSE_RWATCH
		&& s_r.cdata == $past(rwatchRes))
		else $error("resource id not recorded");
	cfg_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		cfgRdEn && cfgReady |=> cfgRdValid)
		else $error("accepted scratch read not answered");
	ssr_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b)
		psRdEn && psAddr == `TDB_OFS_SSR
		|=> psRdData[31:11] == 21'h0 && !psRdData[5])
		else $error("reserved status bits read nonzero");
	type_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b)
		psRdEn && psAddr == `TDB_OFS_TYPE
		|=> psRdData[31:18] == 14'h0 && psRdData[7:3] == 5'h00)
		else $error("reserved cause bits read nonzero");
	ibc_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b)
		psRdEn && inGroup(psAddr, `TDB_OFS_IBC, 8'h04)
		|=> psRdData[31:24] == 8'h00 && psRdData[15:2] == 14'h0)
		else $error("reserved control bits read nonzero");

	host_entry_c: cover property (@(posedge clk) disable iff (!rst_b)
		trig && hostEdge);
	ibrk_entry_c: cover property (@(posedge clk) disable iff (!rst_b)
		trig && bpHit ##[1:50] dretReq);
	scr_share_c: cover property (@(posedge clk) disable iff (!rst_b)
		cfgWrEn && !cfgReady);
	dwatch_entry_c: cover property (@(posedge clk) disable iff (!rst_b)
		trig && !bpHit && dwatchHit);
	ret_stop_c: cover property (@(posedge clk) disable iff (!rst_b)
		debugMode && dretReq && s_r.stop != 8'h00);
endmodule // tdb_unit
`default_nettype wire

// [sim/tdb_host_model.sv]
// host debug request source standing in for the test access logic
// assumes the bench pulses go at a clock edge; lag is in ns
`default_nettype none
module tdb_host_model (
	input wire logic go,
	input wire logic [7:0] lag,
	output logic hostReq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial hostReq = 1'b0;
	// arrives off the core clock, so the sync stages see any phase
	always @(posedge go) begin
		#(lag);
		hostReq = 1'b1;
		#200;
		hostReq = 1'b0; // only the rising edge counts, so drop it later
	end
endmodule // tdb_host_model
`default_nettype wire

// [sim/tile_debug_breakpoint_unit_bench.sv]
// self-checking bench for tdb_unit against a register model
// assumes one core clock; the host request comes from tdb_host_model
`include "tdb_cfg.svh"
`default_nettype none
module tile_debug_breakpoint_unit_bench import tdb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, psWrEn = 0, psRdEn = 0, cfgWrEn = 0;
	logic cfgRdEn = 0, exValid = 0, dcallReq = 0, dwatchHit = 0;
	logic rwatchHit = 0, dretReq = 0, go = 0, hostReq;
	logic [7:0] psAddr = 0, exThread = 0, lag = 0;
	logic [31:0] psWrData = 0, cfgWrData = 0, exPc = 0, exSp = 0;
	logic [31:0] dwatchAddr = 0, rwatchRes = 0, psRdData, cfgRdData;
	logic [2:0] cfgAddr = 0;
	logic [10:0] exSsr = 0;
	logic [1:0] dwatchIdx = 0, rwatchIdx = 0;
	logic psRdValid, cfgRdValid, cfgReady, debugEnter, debugMode;
	logic [7:0] threadStop, getRegThread;
	logic [4:0] getRegIndex;
	logic [31:0] mdl [0:255];
	logic [7:0] al [$];
	int bad_count = 0, n_compared = 0;
	tdb_unit dut_u (.clk(clk), .rst_b(rst_b), .psAddr(psAddr),
		.psWrEn(psWrEn), .psRdEn(psRdEn), .psWrData(psWrData),
		.psRdData(psRdData), .psRdValid(psRdValid), .cfgAddr(cfgAddr),
		.cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgWrData(cfgWrData),
		.cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
		.cfgReady(cfgReady), .exValid(exValid), .exThread(exThread),
		.exPc(exPc), .exSsr(exSsr), .exSp(exSp), .hostReq(hostReq),
		.dcallReq(dcallReq), .dwatchHit(dwatchHit),
		.dwatchIdx(dwatchIdx), .dwatchAddr(dwatchAddr),
		.rwatchHit(rwatchHit), .rwatchIdx(rwatchIdx),
		.rwatchRes(rwatchRes), .dretReq(dretReq),
		.debugEnter(debugEnter), .debugMode(debugMode),
		.threadStop(threadStop), .getRegThread(getRegThread),
		.getRegIndex(getRegIndex));
	tdb_host_model host_u (.go(go), .lag(lag), .hostReq(hostReq));
	// 50 MHz core clock
	always #10 clk = ~clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// writable bits per status index; unmapped places keep nothing
	function automatic logic [31:0] msk(input logic [7:0] a);
		case (a) inside
			8'h10: msk = 32'h6df;
			8'h11, 8'h12, 8'h16, [8'h20:8'h27], [8'h30:8'h33]: msk = '1;
			8'h13, 8'h18: msk = 32'hff;
			8'h14: msk = 32'h1f;
			8'h15: msk = 32'h3ff07;
			[8'h40:8'h43]: msk = 32'hff0003;
			default: msk = 32'h0;
		endcase
	endfunction
	// callers start at an edge; one idle cycle avoids double assignment
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		psAddr <= a;
		psWrData <= d;
		psWrEn <= 1;
		@(posedge clk);
		psWrEn <= 0;
		mdl[a] = (mdl[a] & ~msk(a)) | (d & msk(a));
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		psAddr <= a;
		psRdEn <= 1;
		@(posedge clk);
		psRdEn <= 0;
		#1 chk(psRdValid, 1);
		v = psRdData;
		@(posedge clk);
	endtask
	task automatic chk_all();
		logic [31:0] v;
		foreach (al[j]) begin
			rd(al[j], v);
			chk(v, mdl[al[j]]);
		end
		chk({getRegIndex, getRegThread},
			{mdl[20][4:0], mdl[19][7:0]});
	endtask
	task automatic cfg(input logic [2:0] a, input logic [31:0] d);
		cfgAddr <= a;
		cfgWrData <= d;
		cfgWrEn <= 1;
		@(posedge clk);
		cfgWrEn <= 0;
		mdl[8'h20 + a] = d;
		@(posedge clk);
	endtask
	// presents one trigger of cause k, checks entry and records the expected capture in the model
	task automatic ev(input logic [2:0] k, input logic [1:0] ix,
		input logic [7:0] th, input logic [31:0] pc, input logic hit);
		logic [31:0] d, sp;
		logic [10:0] ss;
		int w;
		d = $urandom;
		sp = $urandom;
		ss = 11'($urandom);
		lag <= 8'($urandom % 60);
		exValid <= k != 1;
		exThread <= th;
		exPc <= pc;
		exSsr <= ss;
		exSp <= sp;
		dcallReq <= k == 2;
		dwatchHit <= k == 4;
		rwatchHit <= k == 5;
		dwatchIdx <= ix;
		rwatchIdx <= ix;
		dwatchAddr <= d;
		rwatchRes <= d;
		go <= k == 1;
		@(posedge clk);
		{exValid, dcallReq, dwatchHit, rwatchHit, go} <= 0;
		w = 0;
		#1;
		while (debugEnter !== 1'b1 && w < 6) begin
			@(posedge clk);
			#1 w++;
		end
		chk(debugEnter, hit);
		if (hit) begin
			chk({debugMode, threadStop}, 9'h100);
			mdl[16] = ss & 11'h7df;
			mdl[17] = pc;
			mdl[18] = sp;
			mdl[21] = {14'h0, k >= 3 ? ix : 2'h0, k == 1 ? 8'h0 : th,
				5'h0, k};
			mdl[22] = k >= 4 ? d : 0;
		end
		@(posedge clk);
	endtask
	task automatic dret();
		dretReq <= 1;
		@(posedge clk);
		dretReq <= 0;
		@(posedge clk);
		#1 chk({debugMode, threadStop}, {1'b0, mdl[24][7:0]});
		@(posedge clk);
	endtask
	// hang guard: the tests need roughly a thousand cycles
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end
	// main sequence
	initial begin
		logic [31:0] a, v;
		logic [7:0] t;
		void'($urandom(32'h368f50a3));
		foreach (mdl[i]) mdl[i] = 0;
		al = {8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
		al.push_back(8'h18);
		for (int i = 0; i < 8; i++) al.push_back(8'h20 + i);
		for (int i = 0; i < 4; i++) al.push_back(8'h30 + i);
		for (int i = 0; i < 4; i++) al.push_back(8'h40 + i);
		al.push_back(8'h44);
		repeat (4) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		chk_all();
		$display("reset values done");
		foreach (al[j]) wr(al[j], $urandom);
		chk_all();
		$display("register access done");
		for (int i = 0; i < 8; i++) begin
			cfg(3'(i), $urandom);
			wr(8'h20 + 8'(7 - i), $urandom);
		end
		for (int i = 0; i < 8; i++) begin
			cfgAddr <= 3'(i);
			cfgRdEn <= 1;
			@(posedge clk);
			cfgRdEn <= 0;
			#1 chk({cfgRdValid, cfgReady}, 2'b11);
			chk(cfgRdData, mdl[8'h20 + i]);
			@(posedge clk);
		end
		// both ports on scratch at once: status wins, config refused
		a = $urandom;
		psAddr <= 8'h23;
		psWrData <= a;
		psWrEn <= 1;
		cfgAddr <= 3'h4;
		cfgWrData <= ~a;
		cfgWrEn <= 1;
		#1 chk(cfgReady, 0);
		@(posedge clk);
		{psWrEn, cfgWrEn} <= 0;
		mdl[8'h23] = a;
		@(posedge clk);
		chk_all();
		$display("scratch sharing done");
		// random controls from the access test would arm stray breakpoints
		for (int i = 0; i < 4; i++) wr(8'h40 + i, 0);
		for (int i = 0; i < 4; i++) begin
			a = $urandom;
			t = 8'($urandom % 8);
			wr(8'h30 + i, a);
			wr(8'h40 + i, 32'h1 << (16 + t) | 1);
			ev(3, 2'(i), t ^ 8'h1, a, 0);
			ev(3, 2'(i), t, a, 1);
			chk_all();
			dret();
			wr(8'h40 + i, 0);
		end
		wr(8'h40, 32'hff0003);
		ev(3, 0, 5, mdl[48], 0);
		ev(3, 0, 5, ~mdl[48], 1);
		dret();
		wr(8'h40, 0);
		wr(8'h31, a);
		wr(8'h32, a);
		wr(8'h41, 32'hff0001);
		wr(8'h42, 32'hff0001);
		ev(3, 1, 2, a, 1);
		chk_all();
		dret();
		for (int i = 0; i < 4; i++) wr(8'h40 + i, 0);
		$display("breakpoints done");
		for (int k = 1; k < 6; k++) begin
			if (k == 3) continue;
			wr(8'h18, $urandom);
			ev(3'(k), 2'($urandom), 8'($urandom % 8), $urandom, 1);
			ev(2, 1, 1, 0, 0);
			chk_all();
			dret();
		end
		$display("causes done");
		give_verdict();
	end
endmodule // tile_debug_breakpoint_unit_bench
`default_nettype wire
